//--- hw/rgbg_register_bank.sv
// Colour offset and gain register bank behind an AXI4-Lite slave
//
// Notes on behaviour
// - Red, green, blue 8-bit offset codes at successive addresses, reset to 0x80.
// - Writing the shared offset location loads all three offset codes at once.
// - Each offset code drives its channel offset DAC: 260*(code-127.5)/127.5 mV.
// - Gain low register bit 0 is the gain code LSB; high register gives the rest.
// - Writing the shared gain low location copies bit 0 into all three channels.
// - Each channel's 8-bit gain high register holds bits 8..1, reset to 0x0c.
// - Writing the shared gain high location loads all three high registers.
// - Each 9-bit gain code sets amplifier gain 0.66 + code*7.34/511 V/V.
`timescale 1ns/1ps
`default_nettype none

module rgbg_register_bank #(
  parameter int AW = rgbg_pkg::AXI_ADDR_W     // Byte address width
) (
  input  wire logic                            aclk,                 // Clock, 100 MHz
  input  wire logic                            aresetn,              // Sync reset, low active
  input  wire logic                            ce,                   // Clock enable
  // Write address channel
  input  wire logic [AW-1:0]                   s_axi_awaddr,         // Write byte address
  input  wire logic [2:0]                      s_axi_awprot,         // Unused protection
  input  wire logic                            s_axi_awvalid,        // Write address valid
  output logic                                 s_axi_awready,        // Write address ready
  // Write data channel
  input  wire logic [rgbg_pkg::AXI_DATA_W-1:0] s_axi_wdata,          // Write data
  input  wire logic [rgbg_pkg::AXI_STRB_W-1:0] s_axi_wstrb,          // Byte enables
  input  wire logic                            s_axi_wvalid,         // Write data valid
  output logic                                 s_axi_wready,         // Write data ready
  // Write response channel
  output logic [1:0]                           s_axi_bresp,          // Write response
  output logic                                 s_axi_bvalid,         // Write response valid
  input  wire logic                            s_axi_bready,         // Write response ready
  // Read address channel
  input  wire logic [AW-1:0]                   s_axi_araddr,         // Read byte address
  input  wire logic [2:0]                      s_axi_arprot,         // Unused protection
  input  wire logic                            s_axi_arvalid,        // Read address valid
  output logic                                 s_axi_arready,        // Read address ready
  // Read data channel
  output logic [rgbg_pkg::AXI_DATA_W-1:0]      s_axi_rdata,          // Read data
  output logic [1:0]                           s_axi_rresp,          // Read response
  output logic                                 s_axi_rvalid,         // Read data valid
  input  wire logic                            s_axi_rready,         // Read data ready
  // Codes to the analogue channels
  output logic [rgbg_pkg::CODE_W-1:0]          red_offset_value,     // Red offset DAC code
  output logic [rgbg_pkg::CODE_W-1:0]          green_offset_value,   // Green offset DAC code
  output logic [rgbg_pkg::CODE_W-1:0]          blue_offset_value,    // Blue offset DAC code
  output logic [rgbg_pkg::GAIN_W-1:0]          red_gain_code,        // Red amplifier gain code
  output logic [rgbg_pkg::GAIN_W-1:0]          green_gain_code,      // Green amplifier gain code
  output logic [rgbg_pkg::GAIN_W-1:0]          blue_gain_code        // Blue amplifier gain code
);
  import rgbg_pkg::*;

  // Write path state
  logic              aw_held;
  logic              w_held;
  logic [IDX_W-1:0]  aw_idx_q;
  logic [CODE_W-1:0] w_byte_q;
  logic              w_lane_q;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_aw_held;
  logic              next_w_held;
  logic [IDX_W-1:0]  next_aw_idx_q;
  logic [CODE_W-1:0] next_w_byte_q;
  logic              next_w_lane_q;

  // Write path decode
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic [IDX_W-1:0]  wr_idx;
  logic [CODE_W-1:0] wr_byte;
  logic              wr_lane;
  logic              wr_hit;
  logic              wr_en;

  // Read path state and decode
  logic                  ar_take;
  logic [IDX_W-1:0]      rd_idx;
  logic                  rd_hit;
  logic [AXI_DATA_W-1:0] rd_word;
  logic                  next_arready;
  logic                  next_rvalid;
  logic [AXI_DATA_W-1:0] next_rdata;
  logic [1:0]            next_rresp;

  // Per-channel strobes and stored codes
  logic [NUM_CH-1:0] ch_wr_offset;
  logic [NUM_CH-1:0] ch_wr_gain_low;
  logic [NUM_CH-1:0] ch_wr_gain_high;
  logic [CODE_W-1:0] ch_offset [NUM_CH];
  logic [GAIN_W-1:0] ch_gain   [NUM_CH];

  // Index of the word addressed on each channel
  assign wr_idx  = aw_held ? aw_idx_q : s_axi_awaddr[IDX_LSB +: IDX_W];
  assign rd_idx  = s_axi_araddr[IDX_LSB +: IDX_W];
  assign wr_byte = w_held ? w_byte_q : s_axi_wdata[CODE_W-1:0];
  assign wr_lane = w_held ? w_lane_q : s_axi_wstrb[LANE0];

  // Write address hit: channel registers plus the shared locations
  always_comb begin
    wr_hit = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (wr_idx == OFFSET_IDX[c] || wr_idx == GAIN_LOW_IDX[c] ||
          wr_idx == GAIN_HIGH_IDX[c]) begin
        wr_hit = 1'b1;
      end
    end
    if (wr_idx == IDX_ALL_OFFSET || wr_idx == IDX_ALL_GAIN_LOW ||
        wr_idx == IDX_ALL_GAIN_HIGH) begin
      wr_hit = 1'b1;
    end
  end

  // Per-channel strobes; shared locations fan out to every channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_wr_offset[c]    = wr_en && (wr_idx == OFFSET_IDX[c] ||
                                     wr_idx == IDX_ALL_OFFSET);
      ch_wr_gain_low[c]  = wr_en && (wr_idx == GAIN_LOW_IDX[c] ||
                                     wr_idx == IDX_ALL_GAIN_LOW);
      ch_wr_gain_high[c] = wr_en && (wr_idx == GAIN_HIGH_IDX[c] ||
                                     wr_idx == IDX_ALL_GAIN_HIGH);
    end
  end

  // Write handshake: address and data taken in either order, then a response
  always_comb begin
    aw_take       = s_axi_awvalid && s_axi_awready;
    w_take        = s_axi_wvalid && s_axi_wready;
    next_aw_held  = aw_held || aw_take;
    next_w_held   = w_held || w_take;
    next_aw_idx_q = aw_take ? s_axi_awaddr[IDX_LSB +: IDX_W] : aw_idx_q;
    next_w_byte_q = w_take ? s_axi_wdata[CODE_W-1:0] : w_byte_q;
    next_w_lane_q = w_take ? s_axi_wstrb[LANE0] : w_lane_q;
    next_bvalid   = s_axi_bvalid && !s_axi_bready;
    next_bresp    = s_axi_bresp;
    wr_fire       = next_aw_held && next_w_held && !s_axi_bvalid;
    wr_en         = wr_fire && wr_hit && wr_lane;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_DECERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  // Write path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx_q      <= '0;
      w_byte_q      <= '0;
      w_lane_q      <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_idx_q      <= next_aw_idx_q;
      w_byte_q      <= next_w_byte_q;
      w_lane_q      <= next_w_lane_q;
    end
  end

  // Read decode; gain low reads keep bits 7..1 zero, shared locations read zero
  always_comb begin
    rd_hit  = 1'b0;
    rd_word = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (rd_idx == OFFSET_IDX[c]) begin
        rd_hit               = 1'b1;
        rd_word[CODE_W-1:0]  = ch_offset[c];
      end
      if (rd_idx == GAIN_LOW_IDX[c]) begin
        rd_hit                = 1'b1;
        rd_word[GAIN_LOW_BIT] = ch_gain[c][GAIN_LOW_BIT];
      end
      if (rd_idx == GAIN_HIGH_IDX[c]) begin
        rd_hit               = 1'b1;
        rd_word[CODE_W-1:0]  = ch_gain[c][GAIN_W-1:1];
      end
    end
    if (rd_idx == IDX_ALL_OFFSET || rd_idx == IDX_ALL_GAIN_LOW ||
        rd_idx == IDX_ALL_GAIN_HIGH) begin
      rd_hit = 1'b1;
    end
  end

  // Read handshake: one read under way, data held until taken
  always_comb begin
    ar_take     = s_axi_arvalid && s_axi_arready;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_DECERR;
    end
    next_arready = !next_rvalid;
  end

  // Read path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // One register set per colour channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    rgbg_channel_regs #(
      .CW            (CODE_W),
      .OFFSET_RST    (OFFSET_RESET),
      .GAIN_HIGH_RST (GAIN_HIGH_RESET),
      .GAIN_LOW_RST  (GAIN_LOW_RESET)
    ) u_regs (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .ce           (ce),
      .wr_offset    (ch_wr_offset[c]),
      .wr_gain_low  (ch_wr_gain_low[c]),
      .wr_gain_high (ch_wr_gain_high[c]),
      .wr_data      (wr_byte),
      .offset_code  (ch_offset[c]),
      .gain_code    (ch_gain[c])
    );
  end

  // Stored codes go straight to the offset DACs and amplifiers
  assign red_offset_value   = ch_offset[CH_RED];
  assign green_offset_value = ch_offset[CH_GREEN];
  assign blue_offset_value  = ch_offset[CH_BLUE];
  assign red_gain_code      = ch_gain[CH_RED];
  assign green_gain_code    = ch_gain[CH_GREEN];
  assign blue_gain_code     = ch_gain[CH_BLUE];

endmodule : rgbg_register_bank

`default_nettype wire

//--- hw/rgbg_pkg.sv
// Shared constants for the colour offset and gain register bank
package rgbg_pkg;

  // Widths
  localparam int IDX_W       = 6;   // Register index width
  localparam int IDX_LSB     = 2;   // Byte address bit where the index starts
  localparam int AXI_ADDR_W  = 8;   // Byte address width on the bus
  localparam int AXI_DATA_W  = 32;  // Bus data width
  localparam int AXI_STRB_W  = 4;   // Byte enables
  localparam int CODE_W      = 8;   // Offset code and gain high part width
  localparam int GAIN_W      = 9;   // Full gain code width
  localparam int NUM_CH      = 3;   // Red, green, blue
  localparam int CH_RED      = 0;
  localparam int CH_GREEN    = 1;
  localparam int CH_BLUE     = 2;
  localparam int GAIN_LOW_BIT = 0;  // Position of the gain low bit in its register
  localparam int LANE0       = 0;   // Byte lane carrying register data

  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_RED_OFFSET          = 6'h20;
  localparam logic [IDX_W-1:0] IDX_GREEN_OFFSET        = 6'h21;
  localparam logic [IDX_W-1:0] IDX_BLUE_OFFSET         = 6'h22;
  localparam logic [IDX_W-1:0] IDX_ALL_OFFSET          = 6'h23;
  localparam logic [IDX_W-1:0] IDX_RED_GAIN_LOW        = 6'h24;
  localparam logic [IDX_W-1:0] IDX_GREEN_GAIN_LOW      = 6'h25;
  localparam logic [IDX_W-1:0] IDX_BLUE_GAIN_LOW       = 6'h26;
  localparam logic [IDX_W-1:0] IDX_ALL_GAIN_LOW        = 6'h27;
  localparam logic [IDX_W-1:0] IDX_RED_GAIN_HIGH       = 6'h28;
  localparam logic [IDX_W-1:0] IDX_GREEN_GAIN_HIGH     = 6'h29;
  localparam logic [IDX_W-1:0] IDX_BLUE_GAIN_HIGH      = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_ALL_GAIN_HIGH       = 6'h2b;

  // Per-channel index tables, ordered red, green, blue
  localparam logic [IDX_W-1:0] OFFSET_IDX    [NUM_CH] = '{IDX_RED_OFFSET,
                                                          IDX_GREEN_OFFSET,
                                                          IDX_BLUE_OFFSET};
  localparam logic [IDX_W-1:0] GAIN_LOW_IDX  [NUM_CH] = '{IDX_RED_GAIN_LOW,
                                                          IDX_GREEN_GAIN_LOW,
                                                          IDX_BLUE_GAIN_LOW};
  localparam logic [IDX_W-1:0] GAIN_HIGH_IDX [NUM_CH] = '{IDX_RED_GAIN_HIGH,
                                                          IDX_GREEN_GAIN_HIGH,
                                                          IDX_BLUE_GAIN_HIGH};

  // Reset values
  localparam logic [CODE_W-1:0] OFFSET_RESET    = 8'h80;
  localparam logic [CODE_W-1:0] GAIN_HIGH_RESET = 8'h0c;
  localparam logic              GAIN_LOW_RESET  = 1'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : rgbg_pkg

//--- hw/rgbg_channel_regs.sv
// Offset and gain code registers of one colour channel
`timescale 1ns/1ps
`default_nettype none

module rgbg_channel_regs #(
  parameter int                      CW            = rgbg_pkg::CODE_W,
  parameter logic [CW-1:0]           OFFSET_RST    = rgbg_pkg::OFFSET_RESET,
  parameter logic [CW-1:0]           GAIN_HIGH_RST = rgbg_pkg::GAIN_HIGH_RESET,
  parameter logic                    GAIN_LOW_RST  = rgbg_pkg::GAIN_LOW_RESET
) (
  input  wire logic          aclk,          // Clock
  input  wire logic          aresetn,       // Sync reset, low active
  input  wire logic          ce,            // Clock enable
  input  wire logic          wr_offset,     // Load offset code
  input  wire logic          wr_gain_low,   // Load gain low bit
  input  wire logic          wr_gain_high,  // Load gain high bits
  input  wire logic [CW-1:0] wr_data,       // Write byte
  output logic      [CW-1:0] offset_code,   // Stored offset code
  output logic      [CW:0]   gain_code      // Stored gain code
);
  import rgbg_pkg::*;

  logic [CW-1:0] next_offset_code;
  logic [CW:0]   next_gain_code;

  // Next codes from the decoded strobes
  always_comb begin
    next_offset_code = offset_code;
    next_gain_code   = gain_code;
    if (wr_offset) begin
      next_offset_code = wr_data;
    end
    if (wr_gain_low) begin
      next_gain_code[GAIN_LOW_BIT] = wr_data[GAIN_LOW_BIT];
    end
    if (wr_gain_high) begin
      next_gain_code[CW:1] = wr_data;
    end
  end

  // Registers, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_code <= OFFSET_RST;
      gain_code   <= {GAIN_HIGH_RST, GAIN_LOW_RST};
    end else if (ce) begin
      offset_code <= next_offset_code;
      gain_code   <= next_gain_code;
    end
  end

endmodule : rgbg_channel_regs

`default_nettype wire

//--- dv/rgbg_register_bank_chk.sv
// Port checker for the colour offset and gain register bank
`timescale 1ns/1ps
`default_nettype none
module rgbg_register_bank_chk import rgbg_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic                  aclk,               // Clock
  input wire logic                  aresetn,            // Reset, low active
  input wire logic                  ce,                 // Clock enable
  input wire logic [AW-1:0]         s_axi_awaddr,       // Write address
  input wire logic                  s_axi_awvalid,      // Aw valid
  input wire logic                  s_axi_awready,      // Aw ready
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,        // Write data
  input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,        // Strobes
  input wire logic                  s_axi_wvalid,       // W valid
  input wire logic                  s_axi_wready,       // W ready
  input wire logic [1:0]            s_axi_bresp,        // Write response
  input wire logic                  s_axi_bvalid,       // B valid
  input wire logic                  s_axi_bready,       // B ready
  input wire logic [AW-1:0]         s_axi_araddr,       // Read address
  input wire logic                  s_axi_arvalid,      // Ar valid
  input wire logic                  s_axi_arready,      // Ar ready
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,        // Read data
  input wire logic [1:0]            s_axi_rresp,        // Read response
  input wire logic                  s_axi_rvalid,       // R valid
  input wire logic                  s_axi_rready,       // R ready
  input wire logic [CODE_W-1:0]     red_offset_value,   // Red offset
  input wire logic [CODE_W-1:0]     green_offset_value, // Green offset
  input wire logic [CODE_W-1:0]     blue_offset_value,  // Blue offset
  input wire logic [GAIN_W-1:0]     red_gain_code,      // Red gain
  input wire logic [GAIN_W-1:0]     green_gain_code,    // Green gain
  input wire logic [GAIN_W-1:0]     blue_gain_code      // Blue gain
);
  // Handshake and decode helpers
  wire       wt  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  wire       rt  = s_axi_arvalid && s_axi_arready && ce;
  wire [5:0] wi  = s_axi_awaddr[7:2];
  wire [5:0] ri  = s_axi_araddr[7:2];
  wire       wok = wt && s_axi_wstrb[0];
  wire       mw  = wi >= IDX_RED_OFFSET && wi <= IDX_ALL_GAIN_HIGH;
  wire       shr = ri == IDX_ALL_OFFSET || ri == IDX_ALL_GAIN_LOW || ri == IDX_ALL_GAIN_HIGH;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  write_resp_a: assert property (wt |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered");
  write_decode_a: assert property (wt |=>
    s_axi_bresp == ($past(mw) ? RESP_OKAY : RESP_DECERR))
    else $error("wrong write response");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_resp_a: assert property (rt |=> s_axi_rvalid)
    else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  shared_read_a: assert property (rt && shr |=>
    s_axi_rdata == '0 && s_axi_rresp == RESP_OKAY)
    else $error("shared location returned data");
  offset_bcast_a: assert property (wok && wi == IDX_ALL_OFFSET |=>
    {red_offset_value, green_offset_value, blue_offset_value} == {3{$past(s_axi_wdata[7:0])}})
    else $error("shared offset not applied");
  low_bcast_a: assert property (wok && wi == IDX_ALL_GAIN_LOW |=>
    {red_gain_code[0], green_gain_code[0], blue_gain_code[0]} == {3{$past(s_axi_wdata[0])}})
    else $error("shared gain low not applied");
  high_bcast_a: assert property (wok && wi == IDX_ALL_GAIN_HIGH |=>
    {red_gain_code[8:1], green_gain_code[8:1], blue_gain_code[8:1]} ==
    {3{$past(s_axi_wdata[7:0])}})
    else $error("shared gain high not applied");
  reset_codes_a: assert property ($rose(aresetn) |->
    {red_offset_value, green_offset_value, blue_offset_value} == {3{OFFSET_RESET}} &&
    {red_gain_code, green_gain_code, blue_gain_code} ==
    {3{GAIN_HIGH_RESET, GAIN_LOW_RESET}})
    else $error("codes not at reset values");

  // Main scenarios reached
  cover property (wok && wi == IDX_ALL_OFFSET);
  cover property (rt && shr);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
  cover property (!ce && s_axi_awvalid);
endmodule : rgbg_register_bank_chk

bind rgbg_register_bank rgbg_register_bank_chk #(.AW(AW)) rgbg_register_bank_chk_i (.*);
`default_nettype wire

//--- dv/rgbg_register_bank_test.sv
// Self-checking bench for the colour offset and gain register bank
`timescale 1ns/1ps
`default_nettype none
module rgbg_register_bank_test;
  import rgbg_pkg::*;
  logic        aclk, aresetn, ce, glo [3];
  logic [7:0]  s_axi_awaddr, s_axi_araddr, off [3], ghi [3], oo [3];
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [7:0]  red_offset_value, green_offset_value, blue_offset_value;
  logic [8:0]  red_gain_code, green_gain_code, blue_gain_code, go [3];
  int          err_total = 0;
  int          comparisons = 0;
  // Write sequence: targets, data, strobes
  logic [5:0]  t_i [12] = '{IDX_RED_OFFSET, IDX_GREEN_GAIN_LOW, IDX_BLUE_GAIN_HIGH, IDX_ALL_OFFSET,
    IDX_ALL_GAIN_LOW, IDX_ALL_GAIN_HIGH, IDX_GREEN_OFFSET, 6'h2c, 6'h1f, IDX_ALL_GAIN_HIGH,
    IDX_ALL_GAIN_LOW, IDX_RED_GAIN_HIGH};
  logic [31:0] t_d [12] = '{32'hdead_be5a, 32'h1, 32'hff, 32'ha5, 32'h1, 32'h0, 32'h33,
    32'h11, 32'h22, 32'hff, 32'h0, 32'h80};
  logic [3:0]  t_s [12] = '{4'hf, 4'h1, 4'hf, 4'h1, 4'hf, 4'hf, 4'he, 4'hf, 4'hf, 4'h1, 4'hf, 4'h1};

  assign oo = '{red_offset_value, green_offset_value, blue_offset_value};
  assign go = '{red_gain_code, green_gain_code, blue_gain_code};

  rgbg_register_bank rgbg_register_bank_i (.*);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr  <= {i, 2'h0};
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ce && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (ce && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (ce && s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        return;
      end
    end
    chk(32'h0, 32'h1, "write timeout");
  endtask : wr

  task automatic rdr(input logic [5:0] i);
    @(posedge aclk);
    s_axi_araddr  <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ce && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (ce && s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        return;
      end
    end
    chk(32'h0, 32'h1, "read timeout");
  endtask : rdr

  // Reads every channel location, the shared gain low location and index 0x2c, and compares with the bench model and the code outputs
  task automatic verify();
    for (int c = 0; c < 3; c++) begin
      rdr(OFFSET_IDX[c]);
      chk({rs, rd[29:0]}, {2'h0, 22'h0, off[c]}, "offset");
      rdr(GAIN_LOW_IDX[c]);
      chk(rd, {31'h0, glo[c]}, "gain low");
      rdr(GAIN_HIGH_IDX[c]);
      chk(rd, {24'h0, ghi[c]}, "gain high");
      chk({24'h0, oo[c]}, {24'h0, off[c]}, "offset out");
      chk({23'h0, go[c]}, {23'h0, ghi[c], glo[c]}, "gain out");
    end
    rdr(IDX_ALL_GAIN_LOW);
    chk({rs, rd[29:0]}, {RESP_OKAY, 30'h0}, "shared read");
    rdr(6'h2c);
    chk({rs, rd[29:0]}, {RESP_DECERR, 30'h0}, "unmapped read");
  endtask : verify

  // Writes through the bus, then updates the model
  task automatic put(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s);
    wr(i, d, s);
    chk({30'h0, rs},
        {30'h0, (i >= IDX_RED_OFFSET && i <= IDX_ALL_GAIN_HIGH) ? RESP_OKAY : RESP_DECERR},
        "bresp");
    for (int c = 0; c < 3; c++) begin
      if (s[0] && (i == OFFSET_IDX[c] || i == IDX_ALL_OFFSET)) off[c] = d[7:0];
      if (s[0] && (i == GAIN_LOW_IDX[c] || i == IDX_ALL_GAIN_LOW)) glo[c] = d[0];
      if (s[0] && (i == GAIN_HIGH_IDX[c] || i == IDX_ALL_GAIN_HIGH)) ghi[c] = d[7:0];
    end
    verify();
  endtask : put

  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int c = 0; c < 3; c++) begin
      off[c] = OFFSET_RESET;
      glo[c] = GAIN_LOW_RESET;
      ghi[c] = GAIN_HIGH_RESET;
    end
  endtask : do_reset

  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {aresetn, ce, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    ce = 1'b1;
    do_reset();
    verify();
    for (int k = 0; k < 12; k++) put(t_i[k], t_d[k], t_s[k]);
    // Stalled clock enable holds a pending write
    ce <= 1'h0;
    fork
      wr(IDX_RED_OFFSET, 32'h11, 4'h1);
      begin
        repeat (4) @(posedge aclk);
        chk({24'h0, red_offset_value}, {24'h0, off[0]}, "frozen");
        ce <= 1'h1;
      end
    join
    chk({30'h0, rs}, {30'h0, RESP_OKAY}, "frozen bresp");
    off[0] = 8'h11;
    verify();
    do_reset();
    verify();
    stop_test();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    chk(32'h0, 32'h1, "watchdog");
    stop_test();
  end
endmodule : rgbg_register_bank_test
`default_nettype wire
